/* rtl/crl_params.svh */
// constants for the cdr rate-lock configuration block: offsets, reset
// values, field positions, encodings and timing defaults
// assumes inclusion by bare name; holds definitions only
// Function
// - host selects channel before configuring it
// - mode field 5:4 = 11 uses reference
// - set then clear reset bits restarts acquisition
// - lock on matching rate after reset
// - reference mode derives coarse cap itself
// - divider codes 0000-0001 pick group ratios
// - remaining divider codes pick shared ratios
// - each group checked against its own count
// - mode field resets to binary 11
// - reference speeds acquisition and judges lock
// - coarse cap preset before phase acquisition
// - retimed data stays on channel vco
// - bit 1 resets high, false-lock off
// - reference output is buffered reference input
// - multi-ratio codes switch ratio automatically
// - single-ratio codes hold one fixed ratio
// - manual flag selects host count bits
// - tolerance register holds two 4-bit tolerances
`ifndef CRL_PARAMS_SVH
`define CRL_PARAMS_SVH
// register offsets
`define CRL_OFS_STATUS 8'h02
`define CRL_OFS_RESET 8'h0A
`define CRL_OFS_DIV 8'h2F
`define CRL_OFS_MODE 8'h36
`define CRL_OFS_G0_LO 8'h60
`define CRL_OFS_G0_HI 8'h61
`define CRL_OFS_G1_LO 8'h62
`define CRL_OFS_G1_HI 8'h63
`define CRL_OFS_TOL 8'h64
`define CRL_OFS_CHSEL 8'hFF
// reset values
`define CRL_RST_RESET 8'h00
`define CRL_RST_DIV 8'h02
`define CRL_RST_MODE 8'h30
`define CRL_RST_CNT 8'h00
`define CRL_RST_TOL 8'h00
`define CRL_RST_CHSEL 8'h00
// field positions
`define CRL_DIV_MSB 7
`define CRL_DIV_LSB 4
`define CRL_FLD_BIT 1
`define CRL_MODE_MSB 5
`define CRL_MODE_LSB 4
`define CRL_CDR_MSB 3
`define CRL_CDR_LSB 2
`define CRL_MAN_BIT 7
`define CRL_CHSEL_MSB 1
`define CRL_TOL1_MSB 7
`define CRL_TOL1_LSB 4
`define CRL_TOL0_MSB 3
`define CRL_TOL0_LSB 0
// encodings
`define CRL_REFMODE_ASSIST 2'h3
`define CRL_DIVC_8_1 4'h0
`define CRL_DIVC_124_1 4'h1
`define CRL_DIVC_124 4'h2
`define CRL_DIVC_24 4'h4
`define CRL_DIVC_14 4'h5
`define CRL_DIVC_1248 4'h6
`define CRL_DIVC_2 4'hA
`define CRL_RATIO_1 4'h1
`define CRL_RATIO_2 4'h2
`define CRL_RATIO_4 4'h4
`define CRL_RATIO_8 4'h8
// defaults and timing
`define CRL_AUTO_COUNT 15'h2800
`define CRL_CAP_MID 8'h80
`define CRL_WIN_EDGES 16'h0100
`define CRL_SMB_ADDR 7'h18
`define CRL_SMB_BITS 4'h8
`endif

/* rtl/crl_pkg.sv */
// types shared by the cdr rate-lock configuration block
// assumes the params header is on the include path
`include "crl_params.svh"
package crl_pkg;
	// one channel's configuration bank
	typedef struct packed {
		logic [7:0] cdr_reset_control;
		logic [7:0] rate_divider_select;
		logic [7:0] reference_mode_control;
		logic [7:0] group0_count_low;
		logic [7:0] group0_count_high;
		logic [7:0] group1_count_low;
		logic [7:0] group1_count_high;
		logic [7:0] count_tolerance;
	} crl_bank_t;
	// one channel's acquisition result
	typedef struct packed {
		logic locked;
		logic group;
		logic [1:0] ratio_idx;
		logic [7:0] cap;
	} crl_stat_t;
	typedef enum logic [1:0] {
		CRL_HOLD, CRL_PRESET, CRL_MEASURE, CRL_LOCKED
	} crl_acq_state_t;
	typedef enum logic [3:0] {
		SB_IDLE, SB_ADDR, SB_ADDR_ACK, SB_OFS, SB_OFS_ACK,
		SB_WR, SB_WR_ACK, SB_RD, SB_RD_ACK
	} crl_smb_state_t;
endpackage

/* rtl/crl_div_decode.sv */
// divider code to allowed-ratio masks for both frequency groups
// assumes pure combinational use; mask bit k means ratio 2**k
`timescale 1ns/1ns
`include "crl_params.svh"
module crl_div_decode (
	input wire logic [3:0] i_code,
	output logic [3:0] o_mask0,
	output logic [3:0] o_mask1
);
	// unlisted codes fall back to ratio 1, the safe fixed choice
	always_comb begin
		o_mask0 = `CRL_RATIO_1;
		o_mask1 = `CRL_RATIO_1;
		case (i_code)
			`CRL_DIVC_8_1: begin
				o_mask0 = `CRL_RATIO_8;
			end
			`CRL_DIVC_124_1: begin
				o_mask0 = `CRL_RATIO_1 | `CRL_RATIO_2 | `CRL_RATIO_4;
			end
			`CRL_DIVC_124: begin
				o_mask0 = `CRL_RATIO_1 | `CRL_RATIO_2 | `CRL_RATIO_4;
				o_mask1 = o_mask0;
			end
			`CRL_DIVC_24: begin
				o_mask0 = `CRL_RATIO_2 | `CRL_RATIO_4;
				o_mask1 = o_mask0;
			end
			`CRL_DIVC_14: begin
				o_mask0 = `CRL_RATIO_1 | `CRL_RATIO_4;
				o_mask1 = o_mask0;
			end
			`CRL_DIVC_1248: begin
				o_mask0 = `CRL_RATIO_1 | `CRL_RATIO_2 | `CRL_RATIO_4
					| `CRL_RATIO_8;
				o_mask1 = o_mask0;
			end
			`CRL_DIVC_2: begin
				o_mask0 = `CRL_RATIO_2;
				o_mask1 = `CRL_RATIO_2;
			end
			default: begin
				o_mask0 = `CRL_RATIO_1;
				o_mask1 = `CRL_RATIO_1;
			end
		endcase
	end
endmodule // crl_div_decode

/* rtl/crl_chan_acq.sv */
// one channel's rate-acquisition sequencer and frequency checker
// assumes a window pulse from the reference edge counter and one
// prescaled vco tick per pulse on i_vco_tick, both in i_clk domain
`timescale 1ns/1ns
`include "crl_params.svh"
module crl_chan_acq #(
	parameter logic [14:0] AUTO_COUNT = `CRL_AUTO_COUNT
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire crl_pkg::crl_bank_t i_cfg,
	input wire logic i_window,
	input wire logic i_vco_tick,
	input wire logic i_phase_ok,
	input wire logic i_false_lock,
	output crl_pkg::crl_stat_t o_stat
);
	crl_pkg::crl_acq_state_t state;
	logic [2:0] cand;
	logic settle;
	logic [15:0] meas;
	logic [3:0] mask0, mask1;
	logic [14:0] exp0, exp1;
	logic [15:0] exp_sel, diff;
	logic [3:0] tol_sel;
	logic cdr_hold, ref_assist, fl_en, allowed, in_tol, ok;

	crl_div_decode u_dec (
		.i_code(i_cfg.rate_divider_select[`CRL_DIV_MSB:`CRL_DIV_LSB]),
		.o_mask0(mask0),
		.o_mask1(mask1)
	);

	// configuration decode
	assign cdr_hold = |i_cfg.cdr_reset_control[`CRL_CDR_MSB:`CRL_CDR_LSB];
	assign ref_assist = i_cfg.reference_mode_control[`CRL_MODE_MSB:
		`CRL_MODE_LSB] == `CRL_REFMODE_ASSIST;
	assign fl_en = ~i_cfg.rate_divider_select[`CRL_FLD_BIT];
	assign exp0 = i_cfg.group0_count_high[`CRL_MAN_BIT] ?
		{i_cfg.group0_count_high[6:0], i_cfg.group0_count_low} :
		AUTO_COUNT;
	assign exp1 = i_cfg.group1_count_high[`CRL_MAN_BIT] ?
		{i_cfg.group1_count_high[6:0], i_cfg.group1_count_low} :
		AUTO_COUNT;
	// cand[2] is the group, cand[1:0] the ratio index
	assign allowed = cand[2] ? mask1[cand[1:0]] : mask0[cand[1:0]];
	assign exp_sel = {1'b0, (o_stat.group ? exp1 : exp0)};
	assign tol_sel = o_stat.group ?
		i_cfg.count_tolerance[`CRL_TOL1_MSB:`CRL_TOL1_LSB] :
		i_cfg.count_tolerance[`CRL_TOL0_MSB:`CRL_TOL0_LSB];
	assign diff = (meas >= exp_sel) ? 16'(meas - exp_sel) :
		16'(exp_sel - meas);
	assign in_tol = diff <= {12'h000, tol_sel};
	// without reference assist only the phase and false-lock detectors judge lock
	assign ok = (~ref_assist | in_tol) & i_phase_ok
		& ~(fl_en & i_false_lock);

	// vco ticks are only counted here; data retiming stays on the vco
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meas <= 16'h0000;
		end else if (i_window) begin
			meas <= {15'h0000, i_vco_tick};
		end else if (i_vco_tick) begin
			meas <= 16'(meas + 16'h0001);
		end
	end

	// acquisition sequencer; first window after a preset is partial
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= crl_pkg::CRL_HOLD;
			cand <= 3'h0;
			settle <= 1'b0;
			o_stat <= '0;
		end else if (cdr_hold) begin
			state <= crl_pkg::CRL_HOLD;
			o_stat.locked <= 1'b0;
		end else begin
			case (state)
				crl_pkg::CRL_HOLD: begin
					cand <= 3'h0;
					state <= crl_pkg::CRL_PRESET;
				end
				crl_pkg::CRL_PRESET: begin
					if (allowed) begin
						o_stat.group <= cand[2];
						o_stat.ratio_idx <= cand[1:0];
						o_stat.cap <= ref_assist ? (cand[2] ? exp1[14:7] :
							exp0[14:7]) : `CRL_CAP_MID;
						settle <= 1'b0;
						state <= crl_pkg::CRL_MEASURE;
					end else begin
						cand <= 3'(cand + 3'h1);
					end
				end
				crl_pkg::CRL_MEASURE: begin
					if (i_window) begin
						if (!settle) begin
							settle <= 1'b1;
						end else if (ok) begin
							o_stat.locked <= 1'b1;
							state <= crl_pkg::CRL_LOCKED;
						end else begin
							cand <= 3'(cand + 3'h1);
							state <= crl_pkg::CRL_PRESET;
						end
					end
				end
				default: begin
					if (i_window && !ok) begin
						o_stat.locked <= 1'b0;
						cand <= 3'(cand + 3'h1);
						state <= crl_pkg::CRL_PRESET;
					end
				end
			endcase
		end
	end
endmodule // crl_chan_acq

/* rtl/crl_top.sv */
// cdr rate-lock configuration: smbus slave, banked channel registers,
// reference window timing and per-channel acquisition
// assumes smbus pins and reference input synchronous to I_CLK (250 MHz)
`timescale 1ns/1ns
`include "crl_params.svh"
module crl_top #(
	parameter int NUM_CH = 4,
	parameter logic [6:0] SMB_ADDR = `CRL_SMB_ADDR, // arbitrary value
	parameter logic [15:0] WIN_EDGES = `CRL_WIN_EDGES,
	parameter logic [14:0] AUTO_COUNT = `CRL_AUTO_COUNT
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_SCL,
	input wire logic I_SDA_IN,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	input wire logic I_REF_CLOCK_INPUT,
	output logic O_REF_CLOCK_OUTPUT,
	input wire logic [NUM_CH-1:0] I_VCO_TICK,
	input wire logic [NUM_CH-1:0] I_PHASE_OK,
	input wire logic [NUM_CH-1:0] I_FALSE_LOCK,
	output logic [NUM_CH-1:0] O_LOCK,
	output logic [NUM_CH-1:0] O_GROUP,
	output logic [2*NUM_CH-1:0] O_DIV_RATIO,
	output logic [8*NUM_CH-1:0] O_VCO_COARSE_CAP_SETTING
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	generate
		if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
			$error("NUM_CH must be 1 to 4");
		end
		if (WIN_EDGES < 16'h0002) begin : g_bad_win
			$error("WIN_EDGES must be at least 2");
		end
	endgenerate

	// ************************************************************
	// reference clock pass-through and measurement window
	// ************************************************************
	logic ref_q, ref_rise, window;
	logic [15:0] win_cnt;

	// a plain buffer so a further device can chain from it
	assign O_REF_CLOCK_OUTPUT = I_REF_CLOCK_INPUT;
	assign ref_rise = I_REF_CLOCK_INPUT & ~ref_q;

	// count reference edges; one window pulse per WIN_EDGES edges
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ref_q <= 1'b0;
			win_cnt <= 16'h0000;
			window <= 1'b0;
		end else begin
			ref_q <= I_REF_CLOCK_INPUT;
			window <= 1'b0;
			if (ref_rise) begin
				if (win_cnt == 16'(WIN_EDGES - 16'h0001)) begin
					win_cnt <= 16'h0000;
					window <= 1'b1;
				end else begin
					win_cnt <= 16'(win_cnt + 16'h0001);
				end
			end
		end
	end

	// ************************************************************
	// smbus slave
	// ************************************************************
	crl_pkg::crl_smb_state_t sb_state;
	logic scl_q, sda_q, scl_rise, scl_fall, bus_start, bus_stop;
	logic [3:0] bitc;
	logic [7:0] shreg, ofs, wdata, rd_byte, rdata;
	logic rw, nack, wr_stb;

	// one stage of history for edge and start/stop detection
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= I_SCL;
			sda_q <= I_SDA_IN;
		end
	end

	assign scl_rise = I_SCL & ~scl_q;
	assign scl_fall = ~I_SCL & scl_q;
	assign bus_start = I_SCL & scl_q & sda_q & ~I_SDA_IN;
	assign bus_stop = I_SCL & scl_q & ~sda_q & I_SDA_IN;
	assign O_SDA_OUT = 1'b0; // open drain: only ever pulls low

	// bits are taken on scl rise and driven on scl fall
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sb_state <= crl_pkg::SB_IDLE;
			bitc <= 4'h0;
			shreg <= 8'h00;
			ofs <= 8'h00;
			wdata <= 8'h00;
			rd_byte <= 8'h00;
			rw <= 1'b0;
			nack <= 1'b0;
			wr_stb <= 1'b0;
			O_SDA_OE <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (bus_start) begin
				sb_state <= crl_pkg::SB_ADDR;
				bitc <= 4'h0;
				O_SDA_OE <= 1'b0;
			end else if (bus_stop) begin
				sb_state <= crl_pkg::SB_IDLE;
				O_SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				if (sb_state == crl_pkg::SB_ADDR || sb_state == crl_pkg::SB_OFS
					|| sb_state == crl_pkg::SB_WR) begin
					shreg <= {shreg[6:0], I_SDA_IN};
					bitc <= 4'(bitc + 4'h1);
				end else if (sb_state == crl_pkg::SB_RD) begin
					bitc <= 4'(bitc + 4'h1);
				end else if (sb_state == crl_pkg::SB_RD_ACK) begin
					nack <= I_SDA_IN;
				end
			end else if (scl_fall) begin
				case (sb_state)
					crl_pkg::SB_ADDR: begin
						if (bitc == `CRL_SMB_BITS) begin
							if (shreg[7:1] == SMB_ADDR) begin
								sb_state <= crl_pkg::SB_ADDR_ACK;
								rw <= shreg[0];
								O_SDA_OE <= 1'b1;
							end else begin
								sb_state <= crl_pkg::SB_IDLE;
							end
						end
					end
					crl_pkg::SB_ADDR_ACK: begin
						bitc <= 4'h0;
						if (rw) begin
							sb_state <= crl_pkg::SB_RD;
							rd_byte <= rdata;
							O_SDA_OE <= ~rdata[7];
						end else begin
							sb_state <= crl_pkg::SB_OFS;
							O_SDA_OE <= 1'b0;
						end
					end
					crl_pkg::SB_OFS: begin
						if (bitc == `CRL_SMB_BITS) begin
							ofs <= shreg;
							sb_state <= crl_pkg::SB_OFS_ACK;
							O_SDA_OE <= 1'b1;
						end
					end
					crl_pkg::SB_OFS_ACK, crl_pkg::SB_WR_ACK: begin
						if (sb_state == crl_pkg::SB_WR_ACK) begin
							ofs <= 8'(ofs + 8'h01);
						end
						sb_state <= crl_pkg::SB_WR;
						bitc <= 4'h0;
						O_SDA_OE <= 1'b0;
					end
					crl_pkg::SB_WR: begin
						if (bitc == `CRL_SMB_BITS) begin
							wdata <= shreg;
							wr_stb <= 1'b1;
							sb_state <= crl_pkg::SB_WR_ACK;
							O_SDA_OE <= 1'b1;
						end
					end
					crl_pkg::SB_RD: begin
						if (bitc == `CRL_SMB_BITS) begin
							ofs <= 8'(ofs + 8'h01);
							sb_state <= crl_pkg::SB_RD_ACK;
							O_SDA_OE <= 1'b0;
						end else begin
							rd_byte <= {rd_byte[6:0], 1'b0};
							O_SDA_OE <= ~rd_byte[6];
						end
					end
					crl_pkg::SB_RD_ACK: begin
						if (nack) begin
							sb_state <= crl_pkg::SB_IDLE;
						end else begin
							sb_state <= crl_pkg::SB_RD;
							bitc <= 4'h0;
							rd_byte <= rdata;
							O_SDA_OE <= ~rdata[7];
						end
					end
					default: begin
						O_SDA_OE <= 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// channel select and banked registers
	// ************************************************************
	logic [7:0] chsel;
	logic [1:0] sel;
	crl_pkg::crl_bank_t bank [NUM_CH];
	crl_pkg::crl_stat_t stat [NUM_CH];

	// channel select is shared; it steers every later access
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			chsel <= `CRL_RST_CHSEL;
		end else if (wr_stb && ofs == `CRL_OFS_CHSEL) begin
			chsel <= wdata;
		end
	end

	assign sel = chsel[`CRL_CHSEL_MSB:0];

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic hit;
			// a select beyond NUM_CH reaches no bank at all
			assign hit = wr_stb && (sel == 2'(ch));

			// bank write decode; reset values set reference mode on
			always_ff @(posedge I_CLK or posedge I_RST) begin
				if (I_RST) begin
					bank[ch].cdr_reset_control <= `CRL_RST_RESET;
					bank[ch].rate_divider_select <= `CRL_RST_DIV;
					bank[ch].reference_mode_control <= `CRL_RST_MODE;
					bank[ch].group0_count_low <= `CRL_RST_CNT;
					bank[ch].group0_count_high <= `CRL_RST_CNT;
					bank[ch].group1_count_low <= `CRL_RST_CNT;
					bank[ch].group1_count_high <= `CRL_RST_CNT;
					bank[ch].count_tolerance <= `CRL_RST_TOL;
				end else if (hit) begin
					if (ofs == `CRL_OFS_RESET) begin
						bank[ch].cdr_reset_control <= wdata;
					end else if (ofs == `CRL_OFS_DIV) begin
						bank[ch].rate_divider_select <= wdata;
					end else if (ofs == `CRL_OFS_MODE) begin
						bank[ch].reference_mode_control <= wdata;
					end else if (ofs == `CRL_OFS_G0_LO) begin
						bank[ch].group0_count_low <= wdata;
					end else if (ofs == `CRL_OFS_G0_HI) begin
						bank[ch].group0_count_high <= wdata;
					end else if (ofs == `CRL_OFS_G1_LO) begin
						bank[ch].group1_count_low <= wdata;
					end else if (ofs == `CRL_OFS_G1_HI) begin
						bank[ch].group1_count_high <= wdata;
					end else if (ofs == `CRL_OFS_TOL) begin
						bank[ch].count_tolerance <= wdata;
					end
				end
			end

			crl_chan_acq #(
				.AUTO_COUNT(AUTO_COUNT)
			) u_acq (
				.i_clk(I_CLK),
				.i_rst(I_RST),
				.i_cfg(bank[ch]),
				.i_window(window),
				.i_vco_tick(I_VCO_TICK[ch]),
				.i_phase_ok(I_PHASE_OK[ch]),
				.i_false_lock(I_FALSE_LOCK[ch]),
				.o_stat(stat[ch])
			);

			// channel outputs straight from the sequencer flops
			assign O_LOCK[ch] = stat[ch].locked;
			assign O_GROUP[ch] = stat[ch].group;
			assign O_DIV_RATIO[2*ch +: 2] = stat[ch].ratio_idx;
			assign O_VCO_COARSE_CAP_SETTING[8*ch +: 8] = stat[ch].cap;
		end
	endgenerate

	// ************************************************************
	// read data
	// ************************************************************
	// unmapped offsets and unpopulated channels read as zero
	always_comb begin
		rdata = 8'h00;
		if (ofs == `CRL_OFS_CHSEL) begin
			rdata = chsel;
		end else if (32'(sel) >= NUM_CH) begin
			rdata = 8'h00;
		end else if (ofs == `CRL_OFS_STATUS) begin
			rdata = {4'h0, stat[sel].ratio_idx, stat[sel].group,
				stat[sel].locked};
		end else if (ofs == `CRL_OFS_RESET) begin
			rdata = bank[sel].cdr_reset_control;
		end else if (ofs == `CRL_OFS_DIV) begin
			rdata = bank[sel].rate_divider_select;
		end else if (ofs == `CRL_OFS_MODE) begin
			rdata = bank[sel].reference_mode_control;
		end else if (ofs == `CRL_OFS_G0_LO) begin
			rdata = bank[sel].group0_count_low;
		end else if (ofs == `CRL_OFS_G0_HI) begin
			rdata = bank[sel].group0_count_high;
		end else if (ofs == `CRL_OFS_G1_LO) begin
			rdata = bank[sel].group1_count_low;
		end else if (ofs == `CRL_OFS_G1_HI) begin
			rdata = bank[sel].group1_count_high;
		end else if (ofs == `CRL_OFS_TOL) begin
			rdata = bank[sel].count_tolerance;
		end
	end
endmodule // crl_top

/* sim/crl_smb_host.sv */
// smbus host model: drives scl and the host side of sda
// assumes the bench resolves sda as a pulled-up open-drain wire
`timescale 1ns/1ns
module crl_smb_host #(
	parameter int Q = 4
) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// bus idles released, both lines high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// ************
	// bit level, every change at a falling clock edge
	// ************
	task automatic hc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// sda moves only while scl is low, so no false start or stop
	task automatic bit_x(input logic b, output logic r);
		o_sda = b;
		hc(Q);
		o_scl = 1'b1;
		hc(Q);
		r = i_sda;
		o_scl = 1'b0;
		hc(1);
	endtask
	task automatic start();
		o_sda = 1'b1;
		hc(Q);
		o_scl = 1'b1;
		hc(Q);
		o_sda = 1'b0;
		hc(Q);
		o_scl = 1'b0;
		hc(1);
	endtask
	task automatic stop();
		o_sda = 1'b0;
		hc(Q);
		o_scl = 1'b1;
		hc(Q);
		o_sda = 1'b1;
		hc(Q);
	endtask
	// eight bits then the ninth; ack means sda was seen low on it
	task automatic byte_x(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(m, r);
		ack = ~r;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] o,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k0, k1, k2;
		start();
		byte_x({a, 1'b0}, 1'b1, q, k0);
		byte_x(o, 1'b1, q, k1);
		byte_x(d, 1'b1, q, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// host nack on the data byte ends the read after one byte
	task automatic rd(input logic [6:0] a, input logic [7:0] o,
		output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k0, k1, k2, kn;
		start();
		byte_x({a, 1'b0}, 1'b1, q, k0);
		byte_x(o, 1'b1, q, k1);
		start();
		byte_x({a, 1'b1}, 1'b1, q, k2);
		byte_x(8'hFF, 1'b1, d, kn);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule // crl_smb_host

/* sim/crl_top_props.sv */
// checker for the cdr rate-lock block, top-level ports only
// assumes the bench runs its lock traffic on channel 0
`timescale 1ns/1ns
module crl_top_props #(
	parameter int NUM_CH = 4,
	parameter logic [15:0] WIN_EDGES = 16'h0100
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_SCL,
	input wire logic O_SDA_OE,
	input wire logic I_REF_CLOCK_INPUT,
	input wire logic O_REF_CLOCK_OUTPUT,
	input wire logic [NUM_CH-1:0] I_VCO_TICK,
	input wire logic [NUM_CH-1:0] I_PHASE_OK,
	input wire logic [NUM_CH-1:0] I_FALSE_LOCK,
	input wire logic [NUM_CH-1:0] O_LOCK,
	input wire logic [NUM_CH-1:0] O_GROUP,
	input wire logic [2*NUM_CH-1:0] O_DIV_RATIO,
	input wire logic [8*NUM_CH-1:0] O_VCO_COARSE_CAP_SETTING
);
	// three windows without a tick is well past any judgement
	localparam int QUIET = 30 * WIN_EDGES;
	int quiet;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// cycles since the last channel 0 tick, saturating
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			quiet <= 0;
		else if (I_VCO_TICK[0])
			quiet <= 0;
		else if (quiet <= QUIET)
			quiet <= quiet + 1;
	end
	// ************
	// properties
	// ************
	property p_ref_copy;
		O_REF_CLOCK_OUTPUT == I_REF_CLOCK_INPUT;
	endproperty
	a_ref_copy: assert property (p_ref_copy) else $error("ref copy");
	property p_phase;
		$rose(O_LOCK[0]) |-> $past(I_PHASE_OK[0]);
	endproperty
	a_phase: assert property (p_phase) else $error("lock sans phase");
	property p_false;
		$rose(O_LOCK[0]) |-> !$past(I_FALSE_LOCK[0]);
	endproperty
	a_false: assert property (p_false) else $error("false lock");
	property p_group;
		$changed(O_GROUP[0]) |-> !O_LOCK[0];
	endproperty
	a_group: assert property (p_group) else $error("group moved");
	property p_ratio;
		$changed(O_DIV_RATIO[1:0]) |-> !O_LOCK[0];
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio moved");
	// the coarse preset must settle before any lock is declared
	property p_cap;
		$changed(O_VCO_COARSE_CAP_SETTING[7:0]) |-> (!O_LOCK[0]) [*2];
	endproperty
	a_cap: assert property (p_cap) else $error("cap late");
	property p_quiet;
		quiet > QUIET |-> !O_LOCK[0];
	endproperty
	a_quiet: assert property (p_quiet) else $error("lock no ticks");
	property p_oe;
		$changed(O_SDA_OE) |-> !I_SCL;
	endproperty
	a_oe: assert property (p_oe) else $error("sda moved, scl high");
	c_lock: cover property ($rose(O_LOCK[0]));
	c_grp1: cover property ($rose(O_LOCK[0]) && O_GROUP[0]);
	c_ack: cover property ($rose(O_SDA_OE));
endmodule // crl_top_props
bind crl_top crl_top_props #(.NUM_CH(NUM_CH), .WIN_EDGES(WIN_EDGES)) u_props (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_SCL(I_SCL), .O_SDA_OE(O_SDA_OE),
	.I_REF_CLOCK_INPUT(I_REF_CLOCK_INPUT),
	.O_REF_CLOCK_OUTPUT(O_REF_CLOCK_OUTPUT), .I_VCO_TICK(I_VCO_TICK),
	.I_PHASE_OK(I_PHASE_OK), .I_FALSE_LOCK(I_FALSE_LOCK), .O_LOCK(O_LOCK),
	.O_GROUP(O_GROUP), .O_DIV_RATIO(O_DIV_RATIO),
	.O_VCO_COARSE_CAP_SETTING(O_VCO_COARSE_CAP_SETTING)
);

/* sim/cdr_rate_lock_config_tb_top.sv */
// self-checking bench for the cdr rate-lock block
// assumes the smbus host model and checker are compiled first
`timescale 1ns/1ns
module cdr_rate_lock_config_tb_top;
	localparam logic [6:0] DEV = 7'h18; // arbitrary bus address
	logic clk, rst, scl, sda_h, sda, ref_clk, tick, tick_en, fl, ok, ph;
	logic sda_out, ref_out;
	logic sda_oe;
	logic [3:0] lock, grp;
	logic [7:0] ratio;
	logic [31:0] cap;
	int miscompares, checks_done, seed, sel, c;
	logic [7:0] mdl [4][256];
	logic [7:0] offs [8] = '{8'h0A, 8'h2F, 8'h36, 8'h60, 8'h61, 8'h62,
		8'h63, 8'h64};
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'hA, 4'hC, 4'hD};
	// lowest allowed group 0 ratio, as index k of ratio 2**k
	logic [1:0] low_k [11] = '{2'h3, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h1, 2'h0, 2'h0};
	// pulled-up open-drain wire; a driven high level would never ack
	assign sda = sda_h & ~(sda_oe & ~sda_out);
	// window of 32 reference edges keeps each judgement short
	crl_top #(.WIN_EDGES(16'h0020), .SMB_ADDR(DEV)) dut_u (
		.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA_IN(sda),
		.O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
		.I_REF_CLOCK_INPUT(ref_clk), .O_REF_CLOCK_OUTPUT(ref_out),
		.I_VCO_TICK({4{tick}}), .I_PHASE_OK({4{ph}}),
		.I_FALSE_LOCK({4{fl}}), .O_LOCK(lock), .O_GROUP(grp),
		.O_DIV_RATIO(ratio), .O_VCO_COARSE_CAP_SETTING(cap)
	);
	crl_smb_host host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda(sda_h));
	// ************
	// clocks and vco ticks
	// ************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// 25 MHz reference, edges fall on falling clock edges
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// one tick every other cycle: 160 ticks per window
	always @(negedge clk) tick <= tick_en & ~tick;
	// reference moves on falling edges, so the copy is settled here
	always @(posedge clk) if (!rst) chk("ref out", ref_clk, ref_out);
	// ************
	// checking and bus tasks
	// ************
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	function automatic logic mapped(input logic [7:0] o);
		return o inside {8'h0A, 8'h2F, 8'h36, [8'h60:8'h64]};
	endfunction
	// model follows every accepted write into the selected bank
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		host_u.wr(DEV, o, d, ok);
		chk("write ack", 1'b1, ok);
		if (o == 8'hFF)
			sel = d[1:0];
		else if (mapped(o))
			mdl[sel][o] = d;
	endtask
	task automatic rd(input logic [7:0] o);
		logic [7:0] d;
		host_u.rd(DEV, o, d, ok);
		chk("read ack", 1'b1, ok);
		chk($sformatf("reg %h", o), mapped(o) ? mdl[sel][o] : 8'h00, d);
	endtask
	task automatic cdr_restart();
		wr(8'h0A, 8'h0C);
		wr(8'h0A, 8'h00);
	endtask
	// a lock is awaited; an absence of lock is checked once, after the full span
	task automatic lock_chk(input logic v, input int n, input logic g,
		input logic [1:0] k, input logic [7:0] cp);
		repeat (n) begin
			if (v && lock[0] === 1'b1)
				break;
			@(negedge clk);
		end
		chk("lock", v, lock[0]);
		if (v) begin
			chk("group", g, grp[0]);
			chk("ratio", k, ratio[1:0]);
			chk("cap", cp, cap[7:0]);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ************
	// scenarios
	// ************
	initial begin
		rst = 1'b1;
		tick = 1'b0;
		tick_en = 1'b1;
		fl = 1'b0;
		ph = 1'b1;
		sel = 0;
		seed = 90151;
		foreach (mdl[i, j])
			mdl[i][j] = (j == 8'h2F) ? 8'h02 : (j == 8'h36) ? 8'h30 : 8'h00;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		foreach (offs[i]) rd(offs[i]);
		rd(8'h10);
		host_u.wr(DEV ^ 7'h01, 8'h36, 8'h00, ok);
		chk("foreign address ack", 1'b0, ok);
		// random bank contents must stay in their own channel
		c = 1 + ($unsigned($random(seed)) % 3);
		wr(8'hFF, 8'(c));
		for (int i = 3; i < 8; i++) wr(offs[i], 8'($random(seed)));
		wr(8'hFF, 8'h00);
		for (int i = 3; i < 8; i++) rd(offs[i]);
		wr(8'hFF, 8'(c));
		for (int i = 3; i < 8; i++) rd(offs[i]);
		// channel 0: both groups expect 160 counts, cap preset 1
		wr(8'hFF, 8'h00);
		wr(8'h36, 8'h30);
		wr(8'h60, 8'hA0);
		wr(8'h61, 8'h80);
		wr(8'h62, 8'hA0);
		wr(8'h63, 8'h80);
		wr(8'h64, 8'hFF);
		foreach (codes[i]) begin
			wr(8'h2F, {codes[i], 4'h2});
			cdr_restart();
			lock_chk(1'b1, 2000, 1'b0, low_k[i], 8'h01);
		end
		tick_en = 1'b0;
		lock_chk(1'b0, 1200, 1'b0, 2'h0, 8'h00);
		tick_en = 1'b1;
		// group 0 expects 0x6A0 and fails; group 1 must carry the lock
		wr(8'h2F, 8'h02);
		wr(8'h61, 8'h86);
		cdr_restart();
		lock_chk(1'b1, 4000, 1'b1, 2'h0, 8'h01);
		wr(8'h61, 8'h80);
		wr(8'h2F, 8'h00);
		fl = 1'b1;
		cdr_restart();
		lock_chk(1'b0, 2000, 1'b0, 2'h0, 8'h00);
		fl = 1'b0;
		// a matching count alone must not lock without phase agreement
		ph = 1'b0;
		cdr_restart();
		lock_chk(1'b0, 2000, 1'b0, 2'h0, 8'h00);
		ph = 1'b1;
		cdr_restart();
		lock_chk(1'b1, 4000, 1'b0, 2'h3, 8'h01);
		tally_and_finish();
	end
	// hang guard, well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
endmodule // cdr_rate_lock_config_tb_top
